// ==== imac_pkg.sv ====
// Package with register map, field layout and constants for the I2C master
package imac_pkg;
  // Register byte offsets (APB, one aligned word each)
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_BUF = 12'h008;
  localparam logic [11:0] OFF_RATE = 12'h00C;
  // Control register bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_RSTART = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_ACK = 3;
  localparam int CTRL_ACKVAL = 4;
  localparam int CTRL_EN = 5;
  localparam int CTRL_IE = 6;
  // Status register bit positions; PIF, BCL and WRCOL are write one to clear
  localparam int ST_PIF = 0;
  localparam int ST_BCL = 1;
  localparam int ST_WRCOL = 2;
  localparam int ST_STOPDET = 3;
  localparam int ST_STARTDET = 4;
  localparam int ST_FULL = 5;
  localparam int ST_ACKSTAT = 6;
  localparam int ST_IDLE = 7;
  // Reset values
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;

  typedef struct packed {
    logic scl_i;
    logic sda_i;
  } imac_pins_in_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } imac_pins_out_t;

  typedef enum logic [4:0] {
    ST_IDLE_S = 5'h00,
    ST_S_CHK = 5'h01,
    ST_S_CNT1 = 5'h02,
    ST_S_CNT2 = 5'h03,
    ST_R_CNT1 = 5'h04,
    ST_R_WAIT = 5'h05,
    ST_R_CNT2 = 5'h06,
    ST_R_CNT3 = 5'h07,
    ST_P_WAIT = 5'h08,
    ST_P_CNT1 = 5'h09,
    ST_P_SCLH = 5'h0A,
    ST_P_CNT2 = 5'h0B,
    ST_P_CNT3 = 5'h0C,
    ST_A_CNT1 = 5'h0D,
    ST_A_WAIT = 5'h0E,
    ST_A_CNT2 = 5'h0F,
    ST_T_LOW = 5'h10,
    ST_T_WAIT = 5'h11,
    ST_T_HIGH = 5'h12
  } imac_state_t;
endpackage : imac_pkg

// ==== imac_top.sv ====
// I2C master sequencer: ack, stop, start, arbitration, APB registers
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module imac_top #(
  parameter int RATE_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus pins, open drain
  input wire imac_pkg::imac_pins_in_t pins_in,
  output imac_pkg::imac_pins_out_t pins_out,
  // Interrupt and wake
  input wire logic slave_event,
  output logic port_irq,
  output logic wake_req
);
  // Pin synchronisers; change counts once stages two and three agree
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_f_reg;
  logic sda_f_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      scl_sync_reg <= imac_pkg::SYNC_RST;
      sda_sync_reg <= imac_pkg::SYNC_RST;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], pins_in.scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], pins_in.sda_i};
      if (scl_sync_reg[1] == scl_sync_reg[2])
        scl_f_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2])
        sda_f_reg <= sda_sync_reg[2];
      scl_prev_reg <= scl_f_reg;
      sda_prev_reg <= sda_f_reg;
    end
  end

  wire scl = scl_f_reg;
  wire sda = sda_f_reg;
  // Stop: SDA rises while SCL high; start: SDA falls while SCL high
  wire stop_seen = scl && scl_prev_reg && sda && !sda_prev_reg;
  wire start_seen = scl && scl_prev_reg && !sda && sda_prev_reg;

  // Registers
  logic [7:0] ctrl_reg;
  logic [RATE_W-1:0] rate_reg;
  logic [7:0] buf_reg;
  logic pif_reg, bcl_reg, wrcol_reg, stopdet_reg, startdet_reg;
  logic full_reg, ackstat_reg;
  logic [RATE_W-1:0] div_reg;
  logic div_run_reg;
  logic scl_low_reg, sda_low_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  imac_pkg::imac_state_t state_reg, state_next;

  wire enabled = ctrl_reg[imac_pkg::CTRL_EN];
  wire irq_en = ctrl_reg[imac_pkg::CTRL_IE];

  // APB decode
  wire apb_wr = psel && penable && pwrite;
  wire sel_ctrl = paddr == imac_pkg::OFF_CTRL;
  wire sel_stat = paddr == imac_pkg::OFF_STATUS;
  wire sel_buf = paddr == imac_pkg::OFF_BUF;
  wire sel_rate = paddr == imac_pkg::OFF_RATE;
  wire mapped = sel_ctrl || sel_stat || sel_buf || sel_rate;
  wire wr_ctrl = apb_wr && sel_ctrl;
  wire wr_stat = apb_wr && sel_stat;
  wire wr_buf = apb_wr && sel_buf;
  wire wr_rate = apb_wr && sel_rate;
  wire idle = state_reg == imac_pkg::ST_IDLE_S;
  // Only ack, stop and transmit are sequences in this block that refuse the buffer
  wire in_ack = state_reg inside {imac_pkg::ST_A_CNT1, imac_pkg::ST_A_WAIT,
                                   imac_pkg::ST_A_CNT2};
  wire in_stop = state_reg inside {imac_pkg::ST_P_WAIT, imac_pkg::ST_P_CNT1,
                                    imac_pkg::ST_P_SCLH, imac_pkg::ST_P_CNT2,
                                    imac_pkg::ST_P_CNT3};
  wire in_tx = state_reg inside {imac_pkg::ST_T_LOW, imac_pkg::ST_T_WAIT,
                                  imac_pkg::ST_T_HIGH};
  wire buf_refused = wr_buf && (in_ack || in_stop || in_tx);
  wire buf_accept = wr_buf && !buf_refused && idle && enabled;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  wire [7:0] status_w = {idle, ackstat_reg, full_reg, startdet_reg,
                         stopdet_reg, wrcol_reg, bcl_reg, pif_reg};
  wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_reg} :
                       sel_stat ? {24'h000000, status_w} :
                       sel_buf ? {24'h000000, buf_reg} :
                       sel_rate ? {{(32-RATE_W){1'b0}}, rate_reg} :
                       32'h00000000;

  // Divider; each expiry is one half period of the bus clock
  wire div_done = div_run_reg && (div_reg == '0);
  logic div_load, div_stop;

  // Collision and event terms from the sequencer
  logic bcl_set, pif_set, seq_done, tx_bit_done;
  logic clr_start, clr_rstart, clr_stop, clr_ack;

  always_comb
  begin
    state_next = state_reg;
    div_load = 1'b0;
    div_stop = 1'b0;
    bcl_set = 1'b0;
    pif_set = 1'b0;
    seq_done = 1'b0;
    tx_bit_done = 1'b0;
    clr_start = 1'b0;
    clr_rstart = 1'b0;
    clr_stop = 1'b0;
    clr_ack = 1'b0;
    unique case (state_reg)
      imac_pkg::ST_IDLE_S:
      begin
        if (!enabled)
          state_next = imac_pkg::ST_IDLE_S;
        else if (ctrl_reg[imac_pkg::CTRL_START])
          state_next = imac_pkg::ST_S_CHK;
        else if (ctrl_reg[imac_pkg::CTRL_RSTART])
        begin
          state_next = imac_pkg::ST_R_CNT1;
          div_load = 1'b1;
        end
        else if (ctrl_reg[imac_pkg::CTRL_STOP])
          state_next = imac_pkg::ST_P_WAIT;
        else if (ctrl_reg[imac_pkg::CTRL_ACK])
        begin
          state_next = imac_pkg::ST_A_CNT1;
          div_load = 1'b1;
        end
        else if (buf_accept)
        begin
          state_next = imac_pkg::ST_T_LOW;
          div_load = 1'b1;
        end
      end
      imac_pkg::ST_S_CHK:
        if (!sda || !scl)
        begin
          bcl_set = 1'b1;
          state_next = imac_pkg::ST_IDLE_S;
        end
        else
        begin
          div_load = 1'b1;
          state_next = imac_pkg::ST_S_CNT1;
        end
      imac_pkg::ST_S_CNT1:
        if (!scl && sda)
        begin
          bcl_set = 1'b1;
          state_next = imac_pkg::ST_IDLE_S;
        end
        else if (!sda || div_done)
        begin
          div_load = 1'b1;
          state_next = imac_pkg::ST_S_CNT2;
        end
      imac_pkg::ST_S_CNT2:
        if (div_done)
        begin
          seq_done = 1'b1;
          clr_start = 1'b1;
          state_next = imac_pkg::ST_IDLE_S;
        end
      imac_pkg::ST_R_CNT1:
        if (div_done)
          state_next = imac_pkg::ST_R_WAIT;
      imac_pkg::ST_R_WAIT:
        if (scl)
        begin
          if (!sda)
          begin
            bcl_set = 1'b1;
            state_next = imac_pkg::ST_IDLE_S;
          end
          else
          begin
            div_load = 1'b1;
            state_next = imac_pkg::ST_R_CNT2;
          end
        end
      imac_pkg::ST_R_CNT2:
        if (!scl && sda)
        begin
          bcl_set = 1'b1;
          state_next = imac_pkg::ST_IDLE_S;
        end
        else if (div_done || !sda)
        begin
          div_load = 1'b1;
          state_next = imac_pkg::ST_R_CNT3;
        end
      imac_pkg::ST_R_CNT3:
        if (div_done)
        begin
          seq_done = 1'b1;
          clr_rstart = 1'b1;
          state_next = imac_pkg::ST_IDLE_S;
        end
      imac_pkg::ST_P_WAIT:
        if (!sda)
        begin
          div_load = 1'b1;
          state_next = imac_pkg::ST_P_CNT1;
        end
      imac_pkg::ST_P_CNT1:
        if (div_done)
          state_next = imac_pkg::ST_P_SCLH;
      imac_pkg::ST_P_SCLH:
        if (scl)
        begin
          div_load = 1'b1;
          state_next = imac_pkg::ST_P_CNT2;
        end
      imac_pkg::ST_P_CNT2:
        if (!scl)
        begin
          bcl_set = 1'b1;
          state_next = imac_pkg::ST_IDLE_S;
        end
        else if (div_done)
        begin
          div_load = 1'b1;
          state_next = imac_pkg::ST_P_CNT3;
        end
      imac_pkg::ST_P_CNT3:
        if (!sda && div_done)
        begin
          bcl_set = 1'b1;
          state_next = imac_pkg::ST_IDLE_S;
        end
        else if (div_done)
        begin
          seq_done = 1'b1;
          clr_stop = 1'b1;
          state_next = imac_pkg::ST_IDLE_S;
        end
      imac_pkg::ST_A_CNT1:
        if (div_done)
          state_next = imac_pkg::ST_A_WAIT;
      imac_pkg::ST_A_WAIT:
        if (scl)
        begin
          if (!ctrl_reg[imac_pkg::CTRL_ACKVAL] || sda)
          begin
            div_load = 1'b1;
            state_next = imac_pkg::ST_A_CNT2;
          end
          else
          begin
            bcl_set = 1'b1;
            state_next = imac_pkg::ST_IDLE_S;
          end
        end
      imac_pkg::ST_A_CNT2:
        if (div_done)
        begin
          seq_done = 1'b1;
          clr_ack = 1'b1;
          div_stop = 1'b1;
          state_next = imac_pkg::ST_IDLE_S;
        end
      imac_pkg::ST_T_LOW:
        if (div_done)
          state_next = imac_pkg::ST_T_WAIT;
      imac_pkg::ST_T_WAIT:
        if (scl)
        begin
          if (shift_reg[7] && !sda && bit_cnt_reg != 4'h8)
          begin
            bcl_set = 1'b1;
            state_next = imac_pkg::ST_IDLE_S;
          end
          else
          begin
            div_load = 1'b1;
            state_next = imac_pkg::ST_T_HIGH;
          end
        end
      imac_pkg::ST_T_HIGH:
        if (div_done)
        begin
          tx_bit_done = 1'b1;
          div_load = 1'b1;
          state_next = (bit_cnt_reg == 4'h8) ? imac_pkg::ST_IDLE_S :
                       imac_pkg::ST_T_LOW;
        end
      default:
        state_next = imac_pkg::ST_IDLE_S;
    endcase
    if (!enabled)
      state_next = imac_pkg::ST_IDLE_S;
  end

  // Collision in any phase clears all triggers and releases both lines
  wire abort = bcl_set || !enabled;
  wire done_bit9 = tx_bit_done && bit_cnt_reg == 4'h8;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_reg <= imac_pkg::ST_IDLE_S;
      div_reg <= '0;
      div_run_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (div_load)
      begin
        div_reg <= rate_reg;
        div_run_reg <= 1'b1;
      end
      else if (div_stop || abort || state_next == imac_pkg::ST_IDLE_S)
        div_run_reg <= 1'b0;
      else if (div_run_reg && div_reg != '0)
        div_reg <= div_reg - 1'b1;
    end
  end

  // Line drive, derived from the next state
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end
    else if (abort)
    begin
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end
    else
      unique case (state_next)
        imac_pkg::ST_S_CNT2: sda_low_reg <= 1'b1;
        imac_pkg::ST_R_CNT1: sda_low_reg <= 1'b0;
        imac_pkg::ST_R_WAIT: scl_low_reg <= 1'b0;
        imac_pkg::ST_R_CNT3: sda_low_reg <= 1'b1;
        imac_pkg::ST_P_WAIT:
        begin
          scl_low_reg <= 1'b1;
          sda_low_reg <= 1'b1;
        end
        imac_pkg::ST_P_SCLH: scl_low_reg <= 1'b0;
        imac_pkg::ST_P_CNT3: sda_low_reg <= 1'b0;
        imac_pkg::ST_A_CNT1:
        begin
          scl_low_reg <= 1'b1;
          sda_low_reg <= !ctrl_reg[imac_pkg::CTRL_ACKVAL];
        end
        imac_pkg::ST_A_WAIT: scl_low_reg <= 1'b0;
        imac_pkg::ST_T_LOW:
        begin
          scl_low_reg <= 1'b1;
          sda_low_reg <= (bit_cnt_reg == 4'h8) ? 1'b0 : !shift_reg[7];
        end
        imac_pkg::ST_T_WAIT: scl_low_reg <= 1'b0;
        imac_pkg::ST_IDLE_S:
          // A finished stop must leave SCL released for the next master
          if ((seq_done && !clr_stop) || done_bit9)
            scl_low_reg <= 1'b1;
        default:
        begin
          scl_low_reg <= scl_low_reg;
          sda_low_reg <= sda_low_reg;
        end
      endcase
  end

  // Shifter; a fresh write always starts at the first bit
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      buf_reg <= 8'h00;
      ackstat_reg <= 1'b0;
    end
    else if (buf_accept)
    begin
      buf_reg <= pwdata[7:0];
      shift_reg <= pwdata[7:0];
      bit_cnt_reg <= 4'h0;
    end
    else if (tx_bit_done)
    begin
      if (bit_cnt_reg == 4'h8)
        ackstat_reg <= sda;
      shift_reg <= {shift_reg[6:0], 1'b0};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // Control and status; hardware set wins over software clear
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ctrl_reg <= imac_pkg::CTRL_RST;
      rate_reg <= RATE_W'(imac_pkg::RATE_RST);
      pif_reg <= 1'b0;
      bcl_reg <= 1'b0;
      wrcol_reg <= 1'b0;
      stopdet_reg <= 1'b0;
      startdet_reg <= 1'b0;
      full_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= pwdata[7:0];
      else
      begin
        if (clr_start || abort)
          ctrl_reg[imac_pkg::CTRL_START] <= 1'b0;
        if (clr_rstart || abort)
          ctrl_reg[imac_pkg::CTRL_RSTART] <= 1'b0;
        if (clr_stop || abort)
          ctrl_reg[imac_pkg::CTRL_STOP] <= 1'b0;
        if (clr_ack || abort)
          ctrl_reg[imac_pkg::CTRL_ACK] <= 1'b0;
      end
      if (wr_rate)
        rate_reg <= pwdata[RATE_W-1:0];
      if (wr_stat && pwdata[imac_pkg::ST_PIF])
        pif_reg <= 1'b0;
      if (seq_done || done_bit9 || stop_seen)
        pif_reg <= 1'b1;
      if (wr_stat && pwdata[imac_pkg::ST_BCL])
        bcl_reg <= 1'b0;
      if (bcl_set)
        bcl_reg <= 1'b1;
      if (wr_stat && pwdata[imac_pkg::ST_WRCOL])
        wrcol_reg <= 1'b0;
      if (buf_refused)
        wrcol_reg <= 1'b1;
      if (!enabled)
      begin
        stopdet_reg <= 1'b0;
        startdet_reg <= 1'b0;
      end
      else if (stop_seen)
      begin
        stopdet_reg <= 1'b1;
        startdet_reg <= 1'b0;
      end
      else if (start_seen)
      begin
        startdet_reg <= 1'b1;
        stopdet_reg <= 1'b0;
      end
      if (bcl_set && in_tx)
        full_reg <= 1'b0;
      else if (buf_accept)
        full_reg <= 1'b1;
      else if (tx_bit_done && bit_cnt_reg == 4'h7)
        full_reg <= 1'b0;
    end
  end

  // Read data registered in the setup phase
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  assign pins_out.scl_o = 1'b0;
  assign pins_out.sda_o = 1'b0;
  assign pins_out.scl_oe = scl_low_reg;
  assign pins_out.sda_oe = sda_low_reg;
  // Interrupt level while IE is set; wake lets slave events through while EN and IE are set
  assign port_irq = irq_en && (pif_reg || bcl_reg);
  assign wake_req = irq_en && enabled && slave_event;
endmodule : imac_top

// ==== imac_top_props.sv ====
// Checker of port-level behaviour for the I2C master sequencer
`timescale 1ns/1ps
module imac_top_props #(
  parameter int RATE_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Bus pins
  input wire imac_pkg::imac_pins_in_t pins_in,
  input wire imac_pkg::imac_pins_out_t pins_out,
  // Events
  input wire logic slave_event,
  input wire logic port_irq,
  input wire logic wake_req
);
  // Bounded wait; tests keep the rate small
  localparam int STOP_MAX = 600;
  logic ie_reg, en_reg, ie_next, en_next;
  wire logic ctrl_wr = psel & penable & pwrite & (paddr == imac_pkg::OFF_CTRL);
  wire logic mapped = (paddr == imac_pkg::OFF_CTRL)
    | (paddr == imac_pkg::OFF_STATUS) | (paddr == imac_pkg::OFF_BUF)
    | (paddr == imac_pkg::OFF_RATE);
  assign ie_next = ctrl_wr ? pwdata[imac_pkg::CTRL_IE] : ie_reg;
  assign en_next = ctrl_wr ? pwdata[imac_pkg::CTRL_EN] : en_reg;
  // Shadow of the enables, so irq and wake can be tied to their cause
  always_ff @(posedge clk_sys)
  begin
    ie_reg <= sys_rst ? 1'b0 : ie_next;
    en_reg <= sys_rst ? 1'b0 : en_next;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_sda_let_go;
    $fell(pins_out.sda_oe) && !pins_out.scl_oe && !$past(pins_out.scl_oe)
      && ie_reg && en_reg;
  endsequence
  sequence s_irq_soon;
    ##[1:STOP_MAX] port_irq;
  endsequence
  property p_ready;
    psel && penable |-> pready;
  endproperty
  property p_slverr;
    psel && penable |-> pslverr == !mapped;
  endproperty
  property p_reset_quiet;
    disable iff (1'b0) sys_rst |=> !pins_out.scl_oe && !pins_out.sda_oe
      && !port_irq && prdata == 32'h0000_0000;
  endproperty
  property p_drive_zero;
    pins_out.scl_o == 1'b0 && pins_out.sda_o == 1'b0;
  endproperty
  property p_irq_gate;
    port_irq |-> ie_reg;
  endproperty
  property p_wake;
    wake_req == (ie_reg && en_reg && slave_event);
  endproperty
  property p_scl_release;
    $fell(pins_out.scl_oe) |-> !pins_out.scl_oe [*3];
  endproperty
  property p_sda_setup;
    $rose(pins_out.sda_oe) && pins_out.scl_oe |-> pins_out.scl_oe [*3];
  endproperty
  property p_stop_irq;
    s_sda_let_go |-> s_irq_soon;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_slverr: assert property (p_slverr) else $error("pslverr mismatch");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  a_drive_zero: assert property (p_drive_zero)
    else $error("pin driven high");
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq without enable");
  a_wake: assert property (p_wake)
    else $error("wake mismatch");
  a_scl_release: assert property (p_scl_release)
    else $error("SCL regrabbed too soon");
  a_sda_setup: assert property (p_sda_setup)
    else $error("SCL released too soon after SDA");
  a_stop_irq: assert property (p_stop_irq)
    else $error("no irq after SDA release");
endmodule : imac_top_props

bind imac_top imac_top_props #(.RATE_W(RATE_W)) imac_top_props_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
  .pins_out(pins_out), .slave_event(slave_event), .port_irq(port_irq),
  .wake_req(wake_req));

// ==== imac_bus_model.sv ====
// Bus side model: pull-ups, other masters and a clock-stretching slave
`timescale 1ns/1ps
module imac_bus_model (
  // Clock
  input wire logic clk_sys,
  // Device side
  input wire imac_pkg::imac_pins_out_t pins_out,
  output imac_pkg::imac_pins_in_t pins_in,
  // Scenario control
  input wire logic pull_sda,
  input wire logic pull_scl,
  input wire logic [7:0] stretch
);
  logic [7:0] hold_cnt = 8'h00;
  logic scl_prev = 1'b0;
  logic stretching;
  // Slow slave holds SCL low after release, master must wait to see high
  always @(posedge clk_sys)
  begin
    scl_prev <= pins_out.scl_oe;
    if (scl_prev && !pins_out.scl_oe)
      hold_cnt <= stretch;
    else if (hold_cnt != 8'h00)
      hold_cnt <= hold_cnt - 8'h01;
  end
  assign stretching = (hold_cnt > 8'h01)
    || (scl_prev && !pins_out.scl_oe && stretch != 8'h00);
  // Wired-AND with pull-ups: a released line reads high
  assign pins_in.scl_i = !(pins_out.scl_oe | pull_scl | stretching);
  assign pins_in.sda_i = !(pins_out.sda_oe | pull_sda);
endmodule : imac_bus_model

// ==== i2c_master_ack_stop_arbitration_tb_top.sv ====
// Self-checking bench for the I2C master sequencer
`timescale 1ns/1ps
module i2c_master_ack_stop_arbitration_tb_top;
  localparam logic [31:0] EI = (32'h1 << imac_pkg::CTRL_EN)
    | (32'h1 << imac_pkg::CTRL_IE);
  localparam logic [31:0] FL = (32'h1 << imac_pkg::ST_PIF)
    | (32'h1 << imac_pkg::ST_BCL) | (32'h1 << imac_pkg::ST_WRCOL);
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, t;
  logic [31:0] seed = 32'h0001_5F69;
  imac_pkg::imac_pins_in_t pins_in;
  imac_pkg::imac_pins_out_t pins_out;
  logic slave_event, port_irq, wake_req, pull_sda, pull_scl;
  logic [7:0] stretch, rate;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  imac_top #(.RATE_W(8)) imac_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in(pins_in), .pins_out(pins_out), .slave_event(slave_event),
    .port_irq(port_irq), .wake_req(wake_req));
  imac_bus_model imac_bus_model_i (.clk_sys(clk_sys), .pins_out(pins_out),
    .pins_in(pins_in), .pull_sda(pull_sda), .pull_scl(pull_scl),
    .stretch(stretch));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] flags(input logic p, input logic c,
    input logic w);
    return ({31'h0, p} << imac_pkg::ST_PIF) | ({31'h0, c} << imac_pkg::ST_BCL)
      | ({31'h0, w} << imac_pkg::ST_WRCOL);
  endfunction : flags

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wait_bit(input logic [11:0] a, input int i, input logic v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      n++;
    end
    while (rd[i] !== v && n < 400);
    chk({31'h0, rd[i]}, {31'h0, v});
  endtask : wait_bit

  task automatic pins(input logic s, input logic d);
    chk({30'h0, pins_out.scl_oe, pins_out.sda_oe}, {30'h0, s, d});
  endtask : pins

  // Another master makes a start and then a stop while SCL floats high
  task automatic blip();
    pull_sda <= 1'b1;
    repeat (12) @(posedge clk_sys);
    pull_sda <= 1'b0;
    repeat (12) @(posedge clk_sys);
  endtask : blip

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, slave_event, pull_sda, pull_scl} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    stretch = 8'h00;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, imac_pkg::OFF_CTRL, 32'h0);
    chk(rd, {24'h0, imac_pkg::CTRL_RST});
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, slv}, 32'h1);
    t = rnd();
    rate = 8'h04 + {4'h0, t[3:0]};
    apb(1'b1, imac_pkg::OFF_RATE, {24'h0, rate});
    apb(1'b0, imac_pkg::OFF_RATE, 32'h0);
    chk(rd, {24'h0, rate});
    apb(1'b1, imac_pkg::OFF_CTRL, EI);
    repeat (6)
    begin
      t = rnd();
      slave_event <= t[0];
      @(posedge clk_sys);
      chk({31'h0, wake_req}, {31'h0, slave_event});
    end
    $display("Test setup done");
    for (int v = 0; v < 2; v++)
    begin
      stretch <= (v == 1) ? 8'h06 : 8'h00;
      t = (32'h1 << imac_pkg::CTRL_ACK) | (v << imac_pkg::CTRL_ACKVAL);
      apb(1'b1, imac_pkg::OFF_CTRL, EI | t);
      repeat (2) @(posedge clk_sys);
      pins(1'b1, v == 0);
      apb(1'b1, imac_pkg::OFF_BUF, rnd());
      wait_bit(imac_pkg::OFF_CTRL, imac_pkg::CTRL_ACK, 1'b0);
      pins(1'b1, v == 0);
      apb(1'b0, imac_pkg::OFF_STATUS, 32'h0);
      chk(rd & FL, flags(1'b1, 1'b0, 1'b1));
      apb(1'b1, imac_pkg::OFF_STATUS, FL);
    end
    $display("Test ack done");
    apb(1'b1, imac_pkg::OFF_CTRL, EI | (32'h1 << imac_pkg::CTRL_STOP));
    repeat (2) @(posedge clk_sys);
    pins(1'b1, 1'b1);
    apb(1'b1, imac_pkg::OFF_BUF, rnd());
    wait_bit(imac_pkg::OFF_CTRL, imac_pkg::CTRL_STOP, 1'b0);
    pins(1'b0, 1'b0);
    chk({31'h0, port_irq}, 32'h1);
    apb(1'b0, imac_pkg::OFF_STATUS, 32'h0);
    chk(rd & (FL | 32'h1 << imac_pkg::ST_STOPDET),
      flags(1'b1, 1'b0, 1'b1) | 32'h1 << imac_pkg::ST_STOPDET);
    apb(1'b1, imac_pkg::OFF_STATUS, FL);
    $display("Test stop done");
    pull_sda <= 1'b1;
    // Let the low SDA pass the pin filter before the start looks at it
    repeat (6) @(posedge clk_sys);
    apb(1'b1, imac_pkg::OFF_CTRL, EI | 32'h1 << imac_pkg::CTRL_START);
    wait_bit(imac_pkg::OFF_STATUS, imac_pkg::ST_BCL, 1'b1);
    wait_bit(imac_pkg::OFF_CTRL, imac_pkg::CTRL_START, 1'b0);
    pins(1'b0, 1'b0);
    apb(1'b1, imac_pkg::OFF_STATUS, FL);
    pull_sda <= 1'b0;
    wait_bit(imac_pkg::OFF_STATUS, imac_pkg::ST_PIF, 1'b1);
    apb(1'b1, imac_pkg::OFF_STATUS, FL);
    $display("Test start collision done");
    apb(1'b1, imac_pkg::OFF_CTRL, EI | 32'h1 << imac_pkg::CTRL_START);
    wait_bit(imac_pkg::OFF_CTRL, imac_pkg::CTRL_START, 1'b0);
    pins(1'b1, 1'b1);
    apb(1'b1, imac_pkg::OFF_STATUS, FL);
    pull_sda <= 1'b1;
    apb(1'b1, imac_pkg::OFF_BUF, rnd() | 32'h80);
    wait_bit(imac_pkg::OFF_STATUS, imac_pkg::ST_BCL, 1'b1);
    chk({31'h0, rd[imac_pkg::ST_FULL]}, 32'h0);
    pins(1'b0, 1'b0);
    apb(1'b1, imac_pkg::OFF_STATUS, FL);
    pull_sda <= 1'b0;
    wait_bit(imac_pkg::OFF_STATUS, imac_pkg::ST_PIF, 1'b1);
    apb(1'b1, imac_pkg::OFF_STATUS, FL);
    $display("Test transmit collision done");
    apb(1'b1, imac_pkg::OFF_CTRL, EI | 32'h1 << imac_pkg::CTRL_START);
    wait_bit(imac_pkg::OFF_CTRL, imac_pkg::CTRL_START, 1'b0);
    apb(1'b1, imac_pkg::OFF_STATUS, FL);
    apb(1'b1, imac_pkg::OFF_CTRL, EI | 32'h1 << imac_pkg::CTRL_RSTART);
    pull_sda <= 1'b1;
    for (int n = 0; n < 400 && pins_out.scl_oe !== 1'b0; n++)
      @(posedge clk_sys);
    wait_bit(imac_pkg::OFF_STATUS, imac_pkg::ST_BCL, 1'b1);
    wait_bit(imac_pkg::OFF_CTRL, imac_pkg::CTRL_RSTART, 1'b0);
    pull_sda <= 1'b0;
    repeat (12) @(posedge clk_sys);
    $display("Test repeated start collision done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk({31'h0, port_irq}, 32'h0);
    apb(1'b0, imac_pkg::OFF_RATE, 32'h0);
    chk(rd, {24'h0, imac_pkg::RATE_RST});
    apb(1'b1, imac_pkg::OFF_CTRL, EI);
    blip();
    wait_bit(imac_pkg::OFF_STATUS, imac_pkg::ST_STOPDET, 1'b1);
    apb(1'b1, imac_pkg::OFF_CTRL, 32'h0);
    apb(1'b0, imac_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h18, 32'h0);
    $display("Test reset and disable done");
    tally_and_finish();
  end
endmodule : i2c_master_ack_stop_arbitration_tb_top
